// ### logic/iep_pkg.sv
//==============================================================================
// Interrupt enable and priority register bank constants
//==============================================================================
// Overview of operation
// (R1) Base priority bits 7..6 read 11, ignore writes.
// (R2) Base priority bit 5 sets Timer 2 level.
// (R3) Base priority bit 4 sets UART level.
// (R4) Base bits 3..0: Timer1, ext1, Timer0, ext0 levels.
// (R5) Enable-one bit 7 gates comparator 1 rising.
// (R6) Enable-one bit 6 gates comparator 1 falling.
// (R7) Enable-one bits 5,4 gate comparator 0 rise/fall.
// (R8) Enable-one bit 3 gates counter array requests.
// (R9) Enable-one bit 2 gates ADC window interrupt.
// (R10) Enable-one bit 1 SMBus, bit 0 SPI.
// (R11) Enable-two bit 7 gates crystal valid request.
// (R12) Enable-two bit 6 reserved, reads 0, write 0.
// (R13) Enable-two bits 5..2 gate external 7..4.
// (R14) Enable-two bit 1 ADC end, bit 0 Timer 3.
// (R15) Priority-one bits 7..4 set comparator levels.
// (R16) Priority-one bits 3..0: counter, window, SMBus, SPI.
// (R17) Priority-two bit 7 sets crystal valid level.
// (R18) Priority-two bit 6 reserved, reads 0, write 0.
// (R19) Priority-two bits 5..2 set external 7..4 levels.
// (R20) Priority-two bit 1 ADC end, bit 0 Timer 3.
// (R21) High preempts low; high never preempted; default low.
// (R22) Same cycle: higher level first, then fixed order.
// (R23) Requests sampled and decoded every clock cycle.
// (R24) Request needs flag, own enable and global enable.
// (R25) Writes affect arbitration from the next cycle.
package iep_pkg;

  //============================================================================
  // Register addresses and reset values
  //============================================================================
  localparam logic [7:0] IEP_ADDR_BASE_PRI = 8'hB8;
  localparam logic [7:0] IEP_ADDR_EXT_EN1  = 8'hE6;
  localparam logic [7:0] IEP_ADDR_EXT_EN2  = 8'hE7;
  localparam logic [7:0] IEP_ADDR_EXT_PRI1 = 8'hF6;
  localparam logic [7:0] IEP_ADDR_EXT_PRI2 = 8'hF7;
  localparam logic [7:0] IEP_RESET_VALUE   = 8'h00;

  //============================================================================
  // Writable masks and forced read bits
  //============================================================================
  localparam logic [7:0] IEP_BASE_PRI_WMASK = 8'h3F;
  localparam logic [7:0] IEP_BASE_PRI_ONES  = 8'hC0;
  localparam logic [7:0] IEP_EXT2_WMASK     = 8'hBF;
  localparam logic [7:0] IEP_FULL_WMASK     = 8'hFF;

  //============================================================================
  // Source layout: index is the fixed arbitration order, 0 wins ties
  //============================================================================
  localparam int IEP_NUM_SRC  = 21;
  localparam int IEP_SRC_W    = 5;
  localparam int IEP_RSV_SRC  = 20;
  localparam logic [4:0] IEP_NO_SRC = 5'h1F;

  typedef enum logic [1:0] {
    IEP_LVL_NONE,
    IEP_LVL_LOW,
    IEP_LVL_HIGH
  } iep_level_e;

endpackage

// ### logic/iep_prio_pick.sv
//==============================================================================
// Fixed-order picker: lowest set index wins
//==============================================================================
module iep_prio_pick #(
  parameter int N = 21,
  parameter int W = 5
) (
  // Candidate vector
  input  wire logic [N-1:0] req_i,
  // Result
  output logic              hit_o,
  output logic [W-1:0]      idx_o
);

  initial
  begin
    if (N > (1 << W) - 1)
      $error("iep_prio_pick: index width too small");
  end

  // Scan from the top down so the lowest index is the last to overwrite.
  always_comb
  begin
    hit_o = 1'b0;
    idx_o = '1;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req_i[i])
      begin
        hit_o = 1'b1; // R22
        idx_o = W'(i);
      end
    end
  end

endmodule

// ### logic/iep_sfr_reg.sv
//==============================================================================
// One special function register with a writable bit mask
//==============================================================================
module iep_sfr_reg #(
  parameter logic [7:0] ADDR  = 8'h00,
  parameter logic [7:0] WMASK = 8'hFF
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // Write port
  input  wire logic       wr_en_i,
  input  wire logic [7:0] wr_addr_i,
  input  wire logic [7:0] wr_data_i,
  // Stored value
  output logic [7:0]      value_o
);

  logic       hit;
  logic [7:0] value_r;
  logic [7:0] value_nxt;

  // Masked bits never store, so reserved and unused bits stay at reset.
  assign hit       = wr_en_i && (wr_addr_i == ADDR);
  assign value_nxt = hit ? (wr_data_i & WMASK) : value_r;
  assign value_o   = value_r;

  // Synchronous reset clears the register.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      value_r <= iep_pkg::IEP_RESET_VALUE;
    else
      value_r <= value_nxt;
  end

endmodule

// ### logic/iep_ctrl.sv
//==============================================================================
// Interrupt enable and priority register bank with arbiter
//==============================================================================
module iep_ctrl #(
  parameter int NUM_SRC = iep_pkg::IEP_NUM_SRC
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  // Special function register port
  input  wire logic               sfr_wr_i,
  input  wire logic               sfr_rd_i,
  input  wire logic [7:0]         sfr_addr_i,
  input  wire logic [7:0]         sfr_wdata_i,
  output logic [7:0]              sfr_rdata_o,
  output logic                    sfr_hit_o,
  // Base enables kept outside this block
  input  wire logic               global_en_i,
  input  wire logic [5:0]         base_en_i,
  // Source flags in fixed order
  input  wire logic [NUM_SRC-1:0] src_flag_i,
  // Core service state
  input  wire logic               svc_low_i,
  input  wire logic               svc_high_i,
  // Arbiter result
  output logic                    irq_req_o,
  output logic                    irq_high_o,
  output logic [4:0]              irq_idx_o
);

  initial
  begin
    if (NUM_SRC != iep_pkg::IEP_NUM_SRC)
      $error("iep_ctrl: source count must match the register layout");
  end

  //============================================================================
  // Register storage
  //============================================================================
  logic [7:0] base_interrupt_priority;
  logic [7:0] extended_enable_one;
  logic [7:0] extended_enable_two;
  logic [7:0] extended_priority_one;
  logic [7:0] extended_priority_two;

  iep_sfr_reg #(
    .ADDR  (iep_pkg::IEP_ADDR_BASE_PRI),
    .WMASK (iep_pkg::IEP_BASE_PRI_WMASK)
  ) u_base_pri (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .wr_en_i   (sfr_wr_i),
    .wr_addr_i (sfr_addr_i),
    .wr_data_i (sfr_wdata_i),
    .value_o   (base_interrupt_priority)
  ); // R1

  iep_sfr_reg #(
    .ADDR  (iep_pkg::IEP_ADDR_EXT_EN1),
    .WMASK (iep_pkg::IEP_FULL_WMASK)
  ) u_ext_en1 (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .wr_en_i   (sfr_wr_i),
    .wr_addr_i (sfr_addr_i),
    .wr_data_i (sfr_wdata_i),
    .value_o   (extended_enable_one)
  );

  iep_sfr_reg #(
    .ADDR  (iep_pkg::IEP_ADDR_EXT_EN2),
    .WMASK (iep_pkg::IEP_EXT2_WMASK)
  ) u_ext_en2 (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .wr_en_i   (sfr_wr_i),
    .wr_addr_i (sfr_addr_i),
    .wr_data_i (sfr_wdata_i),
    .value_o   (extended_enable_two)
  ); // R12

  iep_sfr_reg #(
    .ADDR  (iep_pkg::IEP_ADDR_EXT_PRI1),
    .WMASK (iep_pkg::IEP_FULL_WMASK)
  ) u_ext_pri1 (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .wr_en_i   (sfr_wr_i),
    .wr_addr_i (sfr_addr_i),
    .wr_data_i (sfr_wdata_i),
    .value_o   (extended_priority_one)
  );

  iep_sfr_reg #(
    .ADDR  (iep_pkg::IEP_ADDR_EXT_PRI2),
    .WMASK (iep_pkg::IEP_EXT2_WMASK)
  ) u_ext_pri2 (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .wr_en_i   (sfr_wr_i),
    .wr_addr_i (sfr_addr_i),
    .wr_data_i (sfr_wdata_i),
    .value_o   (extended_priority_two)
  ); // R18

  //============================================================================
  // Read decode
  //============================================================================
  logic       addr_hit;
  logic [7:0] rd_mux;
  logic [7:0] sfr_rdata_r;
  logic       sfr_hit_r;

  // The unused top bits of the base priority register always read as ones.
  assign rd_mux =
    (sfr_addr_i == iep_pkg::IEP_ADDR_BASE_PRI) ?
      (base_interrupt_priority | iep_pkg::IEP_BASE_PRI_ONES) : // R1
    (sfr_addr_i == iep_pkg::IEP_ADDR_EXT_EN1)  ? extended_enable_one :
    (sfr_addr_i == iep_pkg::IEP_ADDR_EXT_EN2)  ? extended_enable_two :
    (sfr_addr_i == iep_pkg::IEP_ADDR_EXT_PRI1) ? extended_priority_one :
    (sfr_addr_i == iep_pkg::IEP_ADDR_EXT_PRI2) ? extended_priority_two :
    8'h00;
  assign addr_hit = (sfr_addr_i == iep_pkg::IEP_ADDR_BASE_PRI)
                 || (sfr_addr_i == iep_pkg::IEP_ADDR_EXT_EN1)
                 || (sfr_addr_i == iep_pkg::IEP_ADDR_EXT_EN2)
                 || (sfr_addr_i == iep_pkg::IEP_ADDR_EXT_PRI1)
                 || (sfr_addr_i == iep_pkg::IEP_ADDR_EXT_PRI2);

  // Read data is registered: a read answers one cycle after it is asked.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      sfr_rdata_r <= 8'h00;
      sfr_hit_r   <= 1'b0;
    end
    else
    begin
      sfr_rdata_r <= sfr_rd_i ? rd_mux : 8'h00;
      sfr_hit_r   <= sfr_rd_i && addr_hit;
    end
  end

  assign sfr_rdata_o = sfr_rdata_r;
  assign sfr_hit_o   = sfr_hit_r;

  //============================================================================
  // Per-source enable and priority vectors, fixed order 0..20
  //============================================================================
  logic [NUM_SRC-1:0] src_en;
  logic [NUM_SRC-1:0] src_pri;

  // Base sources: ext0, timer0, ext1, timer1, UART, timer2.
  // Then SPI, SMBus, window, counter array, cmp0 fall/rise, cmp1
  // fall/rise, timer3, ADC end, ext4..7, crystal valid. The reserved
  // bit has no source, so it takes no slot in the vector.
  assign src_en = {
    extended_enable_two[7],                     // R11
    extended_enable_two[5:2],                   // R13
    extended_enable_two[1:0],                   // R14
    extended_enable_one[7], extended_enable_one[6], // R5 R6
    extended_enable_one[5:4],                   // R7
    extended_enable_one[3],                     // R8
    extended_enable_one[2],                     // R9
    extended_enable_one[1:0],                   // R10
    base_en_i
  };

  assign src_pri = {
    extended_priority_two[7],                   // R17
    extended_priority_two[5:2],                 // R19
    extended_priority_two[1:0],                 // R20
    extended_priority_one[7:4],                 // R15
    extended_priority_one[3:0],                 // R16
    base_interrupt_priority[5],                 // R2
    base_interrupt_priority[4],                 // R3
    base_interrupt_priority[3:0]                // R4
  };

  //============================================================================
  // Gating and level split
  //============================================================================
  logic [NUM_SRC-1:0] live;
  logic [NUM_SRC-1:0] live_high;
  logic [NUM_SRC-1:0] live_low;

  // Enables come straight from the stored registers, so a write is seen by
  // the arbiter on the first cycle after it completes.
  assign live      = src_flag_i & src_en & {NUM_SRC{global_en_i}}; // R24 R25
  assign live_high = live & src_pri;
  assign live_low  = live & ~src_pri;

  logic            hi_hit;
  logic            lo_hit;
  logic [4:0]      hi_idx;
  logic [4:0]      lo_idx;

  iep_prio_pick #(
    .N (NUM_SRC),
    .W (iep_pkg::IEP_SRC_W)
  ) u_pick_high (
    .req_i (live_high),
    .hit_o (hi_hit),
    .idx_o (hi_idx)
  );

  iep_prio_pick #(
    .N (NUM_SRC),
    .W (iep_pkg::IEP_SRC_W)
  ) u_pick_low (
    .req_i (live_low),
    .hit_o (lo_hit),
    .idx_o (lo_idx)
  );

  //============================================================================
  // Preemption and final choice
  //============================================================================
  logic                     take_high;
  logic                     take_low;
  iep_pkg::iep_level_e      pick_lvl;

  // A running high routine blocks everything; a running low routine lets
  // only high requests through.
  assign take_high = hi_hit && !svc_high_i;                 // R21
  assign take_low  = lo_hit && !svc_high_i && !svc_low_i;   // R21

  // High level is considered before low in the same cycle.
  assign pick_lvl = take_high ? iep_pkg::IEP_LVL_HIGH :     // R22
                    take_low  ? iep_pkg::IEP_LVL_LOW  :
                    iep_pkg::IEP_LVL_NONE;

  logic       irq_req_r;
  logic       irq_high_r;
  logic [4:0] irq_idx_r;
  logic       req_nxt;
  logic       high_nxt;
  logic [4:0] idx_nxt;

  always_comb
  begin
    case (pick_lvl)
      iep_pkg::IEP_LVL_HIGH:
      begin
        req_nxt  = 1'b1;
        high_nxt = 1'b1;
        idx_nxt  = hi_idx;
      end
      iep_pkg::IEP_LVL_LOW:
      begin
        req_nxt  = 1'b1;
        high_nxt = 1'b0;
        idx_nxt  = lo_idx;
      end
      default:
      begin
        req_nxt  = 1'b0;
        high_nxt = 1'b0;
        idx_nxt  = iep_pkg::IEP_NO_SRC;
      end
    endcase
  end

  // Decision is re-made on every clock, one cycle of detection latency.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      irq_req_r  <= 1'b0;
      irq_high_r <= 1'b0;
      irq_idx_r  <= iep_pkg::IEP_NO_SRC;
    end
    else
    begin
      irq_req_r  <= req_nxt;   // R23
      irq_high_r <= high_nxt;
      irq_idx_r  <= idx_nxt;
    end
  end

  assign irq_req_o  = irq_req_r;
  assign irq_high_o = irq_high_r;
  assign irq_idx_o  = irq_idx_r;

  //============================================================================
  // Assertions
  //============================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  base_top_ones_a: assert property ( // R1
    sfr_rd_i && sfr_addr_i == iep_pkg::IEP_ADDR_BASE_PRI
    |=> sfr_rdata_o[7:6] == 2'b11)
    else $error("base priority top bits not read as ones");

  rsv_en2_zero_a: assert property ( // R12
    sfr_rd_i && sfr_addr_i == iep_pkg::IEP_ADDR_EXT_EN2
    |=> sfr_rdata_o[6] == 1'b0)
    else $error("enable-two reserved bit read as one");

  rsv_pri2_zero_a: assert property ( // R18
    sfr_rd_i && sfr_addr_i == iep_pkg::IEP_ADDR_EXT_PRI2
    |=> sfr_rdata_o[6] == 1'b0)
    else $error("priority-two reserved bit read as one");

  gate_global_a: assert property ( // R24
    !global_en_i |=> !irq_req_o)
    else $error("request raised with global enable off");

  high_blocks_a: assert property ( // R21
    svc_high_i |=> !irq_req_o)
    else $error("high routine was preempted");

  low_only_high_a: assert property ( // R21
    svc_low_i |=> !irq_req_o || irq_high_o)
    else $error("low request preempted a low routine");

  high_first_a: assert property ( // R22
    hi_hit && lo_hit && !svc_high_i |=> irq_req_o && irq_high_o)
    else $error("low level served before high");

  tie_order_a: assert property ( // R22
    take_high |=> irq_idx_o == $past(hi_idx)
      && ($past(live_high)
          & ((NUM_SRC'(1) << irq_idx_o) - NUM_SRC'(1))) == '0)
    else $error("fixed order not used for ties");

  write_next_a: assert property ( // R25
    sfr_wr_i && sfr_addr_i == iep_pkg::IEP_ADDR_EXT_EN1
    |=> extended_enable_one == $past(sfr_wdata_i))
    else $error("enable-one write not visible next cycle");

  every_cycle_a: assert property ( // R23
    rst_b_i |=> irq_req_o == $past(req_nxt))
    else $error("arbiter skipped a cycle");

  masked_quiet_a: assert property ( // R24
    (src_flag_i & src_en) == '0 |=> !irq_req_o)
    else $error("request raised for a masked source");

  cov_high_c: cover property (irq_req_o && irq_high_o);
  cov_low_c: cover property (irq_req_o && !irq_high_o);
  cov_preempt_c: cover property (svc_low_i && irq_req_o && irq_high_o);
  cov_both_c: cover property (hi_hit && lo_hit);

endmodule

// ### tb/iep_core_model.sv
module iep_core_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // Bench commands: enter the offered routine, return from one
  input  wire logic take_i,
  input  wire logic ret_i,
  // Offer from the arbiter
  input  wire logic irq_req_i,
  input  wire logic irq_high_i,
  // Service state seen by the arbiter
  output logic      svc_low_o,
  output logic      svc_high_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic low_r;
  logic high_r;

  //============================================================================
  // Service nesting
  //============================================================================
  // A high routine may nest on a low one; a return always closes the
  // innermost routine, so the low level resumes after the high one ends.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      low_r  <= 1'h0;
      high_r <= 1'h0;
    end
    else if (take_i && irq_req_i)
    begin
      if (irq_high_i)
        high_r <= 1'h1;
      else
        low_r <= 1'h1;
    end
    else if (ret_i)
    begin
      if (high_r)
        high_r <= 1'h0;
      else
        low_r <= 1'h0;
    end
  end

  // The core reports its nesting levels straight from the state.
  assign svc_low_o  = low_r;
  assign svc_high_o = high_r;
endmodule

// ### tb/irq_enable_priority_regs_bench.sv
module irq_enable_priority_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic        glob;
    logic [20:0] en;
    logic [20:0] pri;
    logic [20:0] flag;
    logic        req;
    logic        high;
    logic [4:0]  idx;
  } iep_row_s;

  // Rows: global, enables, levels, flags, then the expected choice.
  localparam iep_row_s ROWS [7] = '{
    '{1'h1, 21'h1FFFFF, 21'h000000, 21'h000003, 1'h1, 1'h0, 5'h00},
    '{1'h1, 21'h1FFFFF, 21'h000002, 21'h000003, 1'h1, 1'h1, 5'h01},
    '{1'h0, 21'h1FFFFF, 21'h000002, 21'h000003, 1'h0, 1'h0, 5'h1F},
    '{1'h1, 21'h1FFFFE, 21'h000000, 21'h000001, 1'h0, 1'h0, 5'h1F},
    '{1'h1, 21'h1FFFFF, 21'h100000, 21'h100001, 1'h1, 1'h1, 5'h14},
    '{1'h1, 21'h1FFFFF, 21'h1FFFFF, 21'h0F0000, 1'h1, 1'h1, 5'h10},
    '{1'h1, 21'h000000, 21'h1FFFFF, 21'h1FFFFF, 1'h0, 1'h0, 5'h1F}};
  localparam logic [7:0] RA [5] = '{iep_pkg::IEP_ADDR_BASE_PRI,
    iep_pkg::IEP_ADDR_EXT_EN1, iep_pkg::IEP_ADDR_EXT_EN2,
    iep_pkg::IEP_ADDR_EXT_PRI1, iep_pkg::IEP_ADDR_EXT_PRI2};
  localparam logic [7:0] RZ [5] = '{8'hC0, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] RF [5] = '{8'hFF, 8'hFF, 8'hBF, 8'hFF, 8'hBF};

  logic        clk;
  logic        rst_b;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_addr;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic        sfr_hit;
  logic        glob;
  logic [5:0]  base_en;
  logic [20:0] flag;
  logic        svc_low;
  logic        svc_high;
  logic        irq_req;
  logic        irq_high;
  logic [4:0]  irq_idx;
  logic        take;
  logic        ret;
  logic [20:0] one;
  int          failures;
  int          checked;

  iep_ctrl dut_u (.clk_i(clk), .rst_b_i(rst_b), .sfr_wr_i(sfr_wr),
    .sfr_rd_i(sfr_rd), .sfr_addr_i(sfr_addr), .sfr_wdata_i(sfr_wdata),
    .sfr_rdata_o(sfr_rdata), .sfr_hit_o(sfr_hit), .global_en_i(glob),
    .base_en_i(base_en), .src_flag_i(flag), .svc_low_i(svc_low),
    .svc_high_i(svc_high), .irq_req_o(irq_req), .irq_high_o(irq_high),
    .irq_idx_o(irq_idx));

  iep_core_model core_u (.clk_i(clk), .rst_b_i(rst_b), .take_i(take),
    .ret_i(ret), .irq_req_i(irq_req), .irq_high_i(irq_high),
    .svc_low_o(svc_low), .svc_high_o(svc_high));

  //============================================================================
  // Clock and run limit
  //============================================================================
  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // A stuck sequence is cut short and counted as a mismatch.
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    wrap_up();
  end

  //============================================================================
  // Shared tasks
  //============================================================================
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_wr    <= 1'h1;
    sfr_addr  <= a;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'h0;
  endtask

  // Read data is registered, so it is looked at just after the edge
  // that takes the strobe and only in that cycle.
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic h);
    @(posedge clk);
    sfr_rd   <= 1'h1;
    sfr_addr <= a;
    @(posedge clk);
    sfr_rd <= 1'h0;
    #1;
    chk("read data", e, sfr_rdata);
    chk("read hit", {7'h0, h}, {7'h0, sfr_hit});
  endtask

  // Spreads a source-ordered vector over the registers it belongs to.
  task automatic cfg(input logic [20:0] en, input logic [20:0] pri);
    wr(iep_pkg::IEP_ADDR_BASE_PRI, {2'h0, pri[5:0]});
    base_en <= en[5:0];
    wr(iep_pkg::IEP_ADDR_EXT_EN1, en[13:6]);
    wr(iep_pkg::IEP_ADDR_EXT_EN2, {en[20], 1'h0, en[19:14]});
    wr(iep_pkg::IEP_ADDR_EXT_PRI1, pri[13:6]);
    wr(iep_pkg::IEP_ADDR_EXT_PRI2, {pri[20], 1'h0, pri[19:14]});
  endtask

  task automatic irq(input logic r, input logic h, input logic [4:0] i);
    repeat (2) @(posedge clk);
    #1;
    chk("request", {7'h0, r}, {7'h0, irq_req});
    chk("level", {7'h0, h}, {7'h0, irq_high});
    chk("source", {3'h0, i}, {3'h0, irq_idx});
  endtask

  task automatic pulse_take(input logic back);
    @(posedge clk);
    take <= ~back;
    ret  <= back;
    @(posedge clk);
    take <= 1'h0;
    ret  <= 1'h0;
  endtask

  task automatic wrap_up();
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  //============================================================================
  // Main sequence
  //============================================================================
  initial
  begin
    rst_b = 1'h0;
    sfr_wr = 1'h0;
    sfr_rd = 1'h0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    glob = 1'h0;
    base_en = 6'h00;
    flag = 21'h000000;
    take = 1'h0;
    ret = 1'h0;
    failures = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    for (int k = 0; k < 5; k++)
    begin
      rd(RA[k], RZ[k], 1'h1);
      wr(RA[k], 8'hFF);
      rd(RA[k], RF[k], 1'h1);
      wr(RA[k], 8'h00);
      rd(RA[k], RZ[k], 1'h1);
    end
    // Unmapped place: writes vanish and reads give nothing.
    wr(8'hE5, 8'hFF);
    rd(8'hE5, 8'h00, 1'h0);
    rd(iep_pkg::IEP_ADDR_EXT_EN1, 8'h00, 1'h1);
    // Read and write in one cycle return the old contents.
    wr(iep_pkg::IEP_ADDR_EXT_EN1, 8'h5A);
    @(posedge clk);
    sfr_wr    <= 1'h1;
    sfr_rd    <= 1'h1;
    sfr_wdata <= 8'hA5;
    @(posedge clk);
    sfr_wr <= 1'h0;
    sfr_rd <= 1'h0;
    #1;
    chk("read old", 8'h5A, sfr_rdata);
    @(posedge clk);
    #1;
    chk("read idle", 8'h00, sfr_rdata);
    rd(iep_pkg::IEP_ADDR_EXT_EN1, 8'hA5, 1'h1);
    for (int r = 0; r < 7; r++)
    begin
      cfg(ROWS[r].en, ROWS[r].pri);
      glob <= ROWS[r].glob;
      flag <= ROWS[r].flag;
      irq(ROWS[r].req, ROWS[r].high, ROWS[r].idx);
    end
    // Each source alone enabled, first high, then low among high others.
    flag <= 21'h1FFFFF;
    for (int s = 0; s < 21; s++)
    begin
      one = 21'h000001 << s;
      cfg(one, one);
      irq(1'h1, 1'h1, s[4:0]);
      cfg(one, ~one);
      irq(1'h1, 1'h0, s[4:0]);
    end
    // A write reaches arbitration one cycle after it completes.
    cfg(21'h000000, 21'h000000);
    flag <= 21'h000040;
    wr(iep_pkg::IEP_ADDR_EXT_EN1, 8'h01);
    #1;
    chk("before", 8'h00, {7'h0, irq_req});
    @(posedge clk);
    #1;
    chk("after", 8'h06, {3'h0, irq_idx});
    // Low routine blocks low, high preempts it, high blocks all.
    cfg(21'h000003, 21'h000002);
    flag <= 21'h000001;
    irq(1'h1, 1'h0, 5'h00);
    pulse_take(1'h0);
    irq(1'h0, 1'h0, 5'h1F);
    flag <= 21'h000003;
    irq(1'h1, 1'h1, 5'h01);
    pulse_take(1'h0);
    irq(1'h0, 1'h0, 5'h1F);
    pulse_take(1'h1);
    irq(1'h1, 1'h1, 5'h01);
    // Second reset in mid-run clears levels back to low. It is held for
    // two edges so the arbiter restarts from cleared registers.
    @(posedge clk);
    rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    #1;
    chk("reset request", 8'h00, {7'h0, irq_req});
    chk("reset source", 8'h1F, {3'h0, irq_idx});
    rd(iep_pkg::IEP_ADDR_BASE_PRI, 8'hC0, 1'h1);
    rd(iep_pkg::IEP_ADDR_EXT_PRI1, 8'h00, 1'h1);
    rd(iep_pkg::IEP_ADDR_EXT_EN2, 8'h00, 1'h1);
    wrap_up();
  end
endmodule
